// ===== create_pkg.sv
// constants for the container-creation leaf
// assumes 64-bit memory words and a 32-bit register port
package create_pkg;
  // ======================================
  // widths
  localparam int ADDR_W = 64;
  localparam int WORD_W = 64;
  localparam int REG_W  = 32;
  localparam int RA_W   = 8;
  localparam int CNT_W  = 9;
  localparam int VA_BITS = 48;
  // ======================================
  // operation and geometry
  localparam logic [31:0] LEAF_CREATE = 32'h0000_0000;
  localparam int PAGE_SHIFT      = 12;
  localparam int DESC_ALIGN_BITS = 5;
  localparam int INFO_ALIGN_BITS = 6;
  localparam logic [CNT_W-1:0] DESC_LAST = 9'h003;
  localparam logic [CNT_W-1:0] INFO_LAST = 9'h007;
  localparam logic [CNT_W-1:0] PAGE_LAST = 9'h1FF;
  localparam int PAGE_WORDS = 512;
  // descriptor word layout
  localparam logic [CNT_W-1:0] D_LIN  = 9'h000;
  localparam logic [CNT_W-1:0] D_SRC  = 9'h001;
  localparam logic [CNT_W-1:0] D_INFO = 9'h002;
  localparam logic [CNT_W-1:0] D_CTL  = 9'h003;
  // security-info record: page type in bits 15:8 of word 0
  localparam int PT_LSB = 8;
  localparam logic [63:0] PT_MASK = 64'h0000_0000_0000_FF00;
  localparam logic [7:0] PT_CONTROL = 8'h00;
  // control page word layout
  localparam logic [CNT_W-1:0] W_SIZE   = 9'h000;
  localparam logic [CNT_W-1:0] W_BASE   = 9'h001;
  localparam logic [CNT_W-1:0] W_FRAME  = 9'h002;
  localparam logic [CNT_W-1:0] W_RSV_LO = 9'h003;
  localparam logic [CNT_W-1:0] W_RSV_HI = 9'h005;
  localparam logic [CNT_W-1:0] W_ATTR   = 9'h006;
  localparam logic [CNT_W-1:0] W_SAVE_FEATURE_MASK   = 9'h007;
  localparam logic [CNT_W-1:0] W_IDS    = 9'h008;
  localparam logic [CNT_W-1:0] W_STATE  = 9'h009;
  localparam int ATTR_WIDE_BIT = 2;
  localparam logic [63:0] SAVE_FEATURE_MASK_REQ  = 64'h0000_0000_0000_0003;
  localparam logic [63:0] HIGH_MASK = 64'hFFFF_FFFF_0000_0000;
  localparam logic [63:0] MIN_SIZE  = 64'h0000_0000_0000_2000;
  localparam logic [63:0] OP_TAG    = 64'h0045_5441_4552_4345;
  // ======================================
  // register map and reset values
  localparam logic [RA_W-1:0] REG_ATTR_LO = 8'h00;
  localparam logic [RA_W-1:0] REG_ATTR_HI = 8'h04;
  localparam logic [RA_W-1:0] REG_FEAT    = 8'h08;
  localparam logic [RA_W-1:0] REG_EXP     = 8'h0C;
  localparam logic [RA_W-1:0] REG_CBASE   = 8'h10;
  localparam logic [RA_W-1:0] REG_CPAGES  = 8'h14;
  localparam logic [RA_W-1:0] REG_STATUS  = 8'h18;
  localparam logic [RA_W-1:0] REG_COUNT   = 8'h1C;
  localparam logic [63:0] ATTR_MASK_RST = 64'h0000_0000_0000_00FF;
  localparam logic [31:0] FEAT_RST      = 32'h0000_0003;
  localparam logic [15:0] EXP_RST       = 16'h3F1F;
  localparam logic [31:0] CBASE_RST     = 32'h0000_0000;
  localparam logic [31:0] CPAGES_RST    = 32'h0000_0100;
endpackage

// ===== container_create.sv
// container creation leaf: checks, page copy, digest seed, page-map write
// assumes same-clock requester, memory port and page-map store
`timescale 1ns/10ps
`default_nettype none
module container_create
(
  input  wire logic                             clock_in,
  input  wire logic                             sys_rst_in,
  input  wire logic [create_pkg::RA_W-1:0]      reg_addr_in,
  input  wire logic [create_pkg::REG_W-1:0]     reg_wdata_in,
  input  wire logic                             reg_wr_in,
  input  wire logic                             reg_rd_in,
  output logic      [create_pkg::REG_W-1:0]     reg_rdata_out,
  input  wire logic                             start_in,
  input  wire logic [31:0]                      leaf_select_reg_in,
  input  wire logic [create_pkg::ADDR_W-1:0]    descriptor_ptr_reg_in,
  input  wire logic [create_pkg::ADDR_W-1:0]    destination_ptr_reg_in,
  input  wire logic [31:0]                      save_need_in,
  output logic                                  busy_out,
  output logic                                  done_out,
  output logic                                  gp_fault_out,
  output logic                                  pf_fault_out,
  output logic      [create_pkg::ADDR_W-1:0]    fault_addr_out,
  output logic                                  mem_req_out,
  output logic      [create_pkg::ADDR_W-1:0]    mem_addr_out,
  input  wire logic [create_pkg::WORD_W-1:0]    mem_data_in,
  input  wire logic                             mem_ack_in,
  input  wire logic                             slot_in_use_in,
  input  wire logic                             slot_valid_in,
  output logic      [31:0]                      slot_index_out,
  output logic                                  slot_we_out,
  output logic      [create_pkg::CNT_W-1:0]     slot_word_out,
  output logic      [create_pkg::WORD_W-1:0]    slot_data_out,
  output logic                                  digest_init_out,
  output logic                                  digest_update_out,
  output logic      [511:0]                     digest_block_out,
  output logic      [31:0]                      digest_count_out,
  output logic                                  pm_we_out,
  output logic      [7:0]                       pm_type_out,
  output logic      [create_pkg::ADDR_W-1:0]    pm_addr_out,
  output logic      [2:0]                       pm_rwx_out,
  output logic      [3:0]                       pm_flags_out,
  output logic                                  pm_valid_out
);
  import create_pkg::*;
  typedef enum logic [3:0] {S_IDLE, S_DESC, S_DCHK, S_INFO, S_SLOT, S_COPY,
                            S_CHECK, S_SEAL, S_MEASURE, S_MAP, S_END} state_t;
  // ======================================
  // helpers
  function automatic logic misaligned(input logic [ADDR_W-1:0] a, input int nbits);
    return (a & ((64'h1 << nbits) - 64'h1)) != 64'h0;
  endfunction
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] b, input logic [CNT_W-1:0] i);
    return b + (ADDR_W'(i) << 3);
  endfunction
  // exponent of 64 or more can never be exceeded by a 64-bit size
  function automatic logic too_large(input logic [63:0] s, input logic [7:0] e);
    if (e >= 8'h40) return 1'b0;
    return (s >> e) != 64'h0;
  endfunction
  // ======================================
  // state
  state_t               state;
  logic [CNT_W-1:0]     cnt, next_cnt;
  logic [ADDR_W-1:0]    rd_base, dest_f;
  logic [63:0]          lin_f, src_f, info_f, ctl_f;
  logic [7:0]           pt_f;
  logic [63:0]          size_f, base_f, attr_f, save_feature_mask_f, attr_mask;
  logic [31:0]          frame_f, feat_mask, cache_base, cache_pages, create_count;
  logic [15:0]          size_exp;
  logic [51:0]          dest_off;
  logic                 rsv_info, rsv_page, dest_hit, wide;
  logic                 chk_save_feature_mask, chk_frame, chk_base, chk_exp;
  logic                 chk_size, chk_align, chk_attr, content_gp;
  assign next_cnt = cnt + 9'h001;
  // page offset of the destination inside the protected page cache
  assign dest_off = destination_ptr_reg_in[63:PAGE_SHIFT] - {20'h00000, cache_base};
  assign dest_hit = (destination_ptr_reg_in[63:PAGE_SHIFT] >= {20'h00000, cache_base})
                    && (dest_off < {20'h00000, cache_pages});
  // ======================================
  // content checks on the copied image
  assign wide      = attr_f[ATTR_WIDE_BIT];
  assign chk_save_feature_mask  = ((save_feature_mask_f & SAVE_FEATURE_MASK_REQ) != SAVE_FEATURE_MASK_REQ) || ((save_feature_mask_f & ~{32'h0000_0000, feat_mask}) != 64'h0);
  assign chk_frame = {frame_f, 12'h000} < {12'h000, save_need_in};
  assign chk_base  = wide ? !(&base_f[63:VA_BITS-1] || ~|base_f[63:VA_BITS-1])
                          : ((base_f & HIGH_MASK) != 64'h0);
  assign chk_exp   = too_large(size_f, wide ? size_exp[15:8] : size_exp[7:0]);
  assign chk_size  = (size_f < MIN_SIZE) || ((size_f & (size_f - 64'h1)) != 64'h0);
  assign chk_align = (base_f & (size_f - 64'h1)) != 64'h0;
  assign chk_attr  = ((attr_f & ~attr_mask) != 64'h0) || rsv_page;
  assign content_gp = chk_save_feature_mask | chk_frame | chk_base | chk_exp | chk_size | chk_align | chk_attr;
  // ======================================
  // sequencing, memory reads and slot writes
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state          <= S_IDLE;
      cnt            <= '0;
      rd_base        <= '0;
      dest_f         <= '0;
      busy_out       <= 1'b0;
      done_out       <= 1'b0;
      gp_fault_out   <= 1'b0;
      pf_fault_out   <= 1'b0;
      fault_addr_out <= '0;
      mem_req_out    <= 1'b0;
      mem_addr_out   <= '0;
      slot_index_out <= '0;
      slot_we_out    <= 1'b0;
      slot_word_out  <= '0;
      slot_data_out  <= '0;
    end else begin
      done_out    <= 1'b0;
      slot_we_out <= 1'b0;
      case (state)
        S_IDLE: begin
          // other leaf values are not ours and are ignored
          if (start_in && leaf_select_reg_in == LEAF_CREATE) begin
            busy_out       <= 1'b1;
            gp_fault_out   <= 1'b0;
            pf_fault_out   <= 1'b0;
            fault_addr_out <= '0;
            dest_f         <= destination_ptr_reg_in;
            slot_index_out <= dest_off[31:0];
            cnt            <= '0;
            if (misaligned(descriptor_ptr_reg_in, DESC_ALIGN_BITS)
                || misaligned(destination_ptr_reg_in, PAGE_SHIFT)) begin
              gp_fault_out <= 1'b1;
              state        <= S_END;
            end else if (!dest_hit) begin
              pf_fault_out   <= 1'b1;
              fault_addr_out <= destination_ptr_reg_in;
              state          <= S_END;
            end else begin
              rd_base      <= descriptor_ptr_reg_in;
              mem_addr_out <= descriptor_ptr_reg_in;
              mem_req_out  <= 1'b1;
              state        <= S_DESC;
            end
          end
        end
        S_DESC, S_INFO, S_COPY: begin
          if (mem_ack_in) begin
            cnt          <= next_cnt;
            mem_addr_out <= word_addr(rd_base, next_cnt);
            if (state == S_COPY) begin
              slot_we_out   <= 1'b1;
              slot_word_out <= cnt;
              slot_data_out <= mem_data_in;
            end
            if ((state == S_DESC && cnt == DESC_LAST)
                || (state == S_INFO && cnt == INFO_LAST)
                || (state == S_COPY && cnt == PAGE_LAST)) begin
              mem_req_out <= 1'b0;
              cnt         <= '0;
              state       <= (state == S_DESC) ? S_DCHK : (state == S_INFO) ? S_SLOT : S_CHECK;
            end
          end
        end
        S_DCHK: begin
          if (misaligned(src_f, PAGE_SHIFT) || misaligned(info_f, INFO_ALIGN_BITS)
              || lin_f != 64'h0 || ctl_f != 64'h0) begin
            gp_fault_out <= 1'b1;
            state        <= S_END;
          end else begin
            rd_base      <= info_f;
            mem_addr_out <= info_f;
            mem_req_out  <= 1'b1;
            state        <= S_INFO;
          end
        end
        S_SLOT: begin
          if (rsv_info || pt_f != PT_CONTROL
              || slot_in_use_in) begin
            gp_fault_out <= 1'b1;
            state        <= S_END;
          end else if (slot_valid_in) begin
            pf_fault_out   <= 1'b1;
            fault_addr_out <= dest_f;
            state          <= S_END;
          end else begin
            rd_base      <= src_f;
            mem_addr_out <= src_f;
            mem_req_out  <= 1'b1;
            state        <= S_COPY;
          end
        end
        S_CHECK: begin
          // the slot already holds the image, but stays invalid on a fault
          if (content_gp) begin
            gp_fault_out <= 1'b1;
            state        <= S_END;
          end else begin
            state <= S_SEAL;
          end
        end
        S_SEAL: begin
          // uninitialized marker, then cleared product id and version
          slot_we_out   <= 1'b1;
          slot_word_out <= (cnt == '0) ? W_STATE : W_IDS;
          slot_data_out <= '0;
          cnt           <= next_cnt;
          if (cnt != '0) begin
            cnt   <= '0;
            state <= S_MEASURE;
          end
        end
        S_MEASURE: state <= S_MAP;
        S_MAP:     state <= S_END;
        S_END: begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          state    <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ======================================
  // field capture from the three reads
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || state == S_IDLE) begin
      lin_f    <= '0;
      src_f    <= '0;
      info_f   <= '0;
      ctl_f    <= '0;
      pt_f     <= '0;
      rsv_info <= 1'b0;
      size_f   <= '0;
      base_f   <= '0;
      frame_f  <= '0;
      attr_f   <= '0;
      save_feature_mask_f   <= '0;
      rsv_page <= 1'b0;
    end else if (mem_ack_in && mem_req_out) begin
      case (state)
        S_DESC: begin
          if (cnt == D_LIN)  lin_f  <= mem_data_in;
          if (cnt == D_SRC)  src_f  <= mem_data_in;
          if (cnt == D_INFO) info_f <= mem_data_in;
          if (cnt == D_CTL)  ctl_f  <= mem_data_in;
        end
        S_INFO: begin
          if (cnt == '0) begin
            pt_f     <= mem_data_in[PT_LSB +: 8];
            rsv_info <= (mem_data_in & ~PT_MASK) != 64'h0;
          end else if (mem_data_in != 64'h0)
            rsv_info <= 1'b1;
        end
        S_COPY: begin
          if (cnt == W_SIZE)  size_f  <= mem_data_in;
          if (cnt == W_BASE)  base_f  <= mem_data_in;
          if (cnt == W_FRAME) frame_f <= mem_data_in[31:0];
          if (cnt == W_ATTR)  attr_f  <= mem_data_in;
          if (cnt == W_SAVE_FEATURE_MASK)  save_feature_mask_f  <= mem_data_in;
          if (cnt >= W_RSV_LO && cnt <= W_RSV_HI && mem_data_in != 64'h0)
            rsv_page <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  // ======================================
  // measurement and page-map entry
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      digest_init_out   <= 1'b0;
      digest_update_out <= 1'b0;
      digest_block_out  <= '0;
      digest_count_out  <= '0;
      pm_we_out         <= 1'b0;
      pm_type_out       <= '0;
      pm_addr_out       <= '0;
      pm_rwx_out        <= '0;
      pm_flags_out      <= '0;
      pm_valid_out      <= 1'b0;
      create_count      <= '0;
    end else begin
      digest_init_out   <= 1'b0;
      digest_update_out <= 1'b0;
      pm_we_out         <= 1'b0;
      if (state == S_CHECK && !content_gp) begin
        digest_init_out  <= 1'b1;
        digest_count_out <= '0;
      end
      if (state == S_MEASURE) begin
        digest_update_out <= 1'b1;
        digest_block_out  <= {352'h0, size_f, frame_f, OP_TAG};
        digest_count_out  <= digest_count_out + 32'h0000_0001;
      end
      // only reached after every check passed
      if (state == S_MAP) begin
        pm_we_out    <= 1'b1;
        pm_type_out  <= PT_CONTROL;
        pm_addr_out  <= '0;
        pm_rwx_out   <= 3'h0;
        pm_flags_out <= 4'h0;
        pm_valid_out <= 1'b1;
        create_count <= create_count + 32'h0000_0001;
      end
    end
  end
  // ======================================
  // register port; writes during a build take effect at once
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      attr_mask   <= ATTR_MASK_RST;
      feat_mask   <= FEAT_RST;
      size_exp    <= EXP_RST;
      cache_base  <= CBASE_RST;
      cache_pages <= CPAGES_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_ATTR_LO: attr_mask[31:0]  <= reg_wdata_in;
        REG_ATTR_HI: attr_mask[63:32] <= reg_wdata_in;
        REG_FEAT:    feat_mask        <= reg_wdata_in;
        REG_EXP:     size_exp         <= reg_wdata_in[15:0];
        REG_CBASE:   cache_base       <= reg_wdata_in;
        REG_CPAGES:  cache_pages      <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  // read data follow the read strobe by one cycle and stand for as long as it is held; unmapped reads return zero
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else begin
      case (reg_addr_in)
        REG_ATTR_LO: reg_rdata_out <= attr_mask[31:0];
        REG_ATTR_HI: reg_rdata_out <= attr_mask[63:32];
        REG_FEAT:    reg_rdata_out <= feat_mask;
        REG_EXP:     reg_rdata_out <= {16'h0000, size_exp};
        REG_CBASE:   reg_rdata_out <= cache_base;
        REG_CPAGES:  reg_rdata_out <= cache_pages;
        REG_STATUS:  reg_rdata_out <= {29'h0, pf_fault_out, gp_fault_out, busy_out};
        REG_COUNT:   reg_rdata_out <= create_count;
        default:     reg_rdata_out <= '0;
      endcase
    end
  end
  // ======================================
  // checks
  logic [9:0] wr_count;
  logic       map_seen;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || state == S_IDLE) begin
      wr_count <= '0;
      map_seen <= 1'b0;
    end else begin
      if (slot_we_out) wr_count <= wr_count + 10'h001;
      if (pm_we_out)   map_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_leaf_ignored: assert property (state == S_IDLE && start_in && leaf_select_reg_in != LEAF_CREATE
    |=> !busy_out ##1 !busy_out) else $error("foreign leaf started a build");
  a_desc_align: assert property (state == S_IDLE && start_in && leaf_select_reg_in == LEAF_CREATE
    && descriptor_ptr_reg_in[4:0] != 5'h00 |=> gp_fault_out ##1 done_out) else $error("misaligned descriptor passed");
  a_dest_outside: assert property (state == S_IDLE && start_in && leaf_select_reg_in == LEAF_CREATE
    && !misaligned(descriptor_ptr_reg_in, DESC_ALIGN_BITS) && !misaligned(destination_ptr_reg_in, PAGE_SHIFT)
    && !dest_hit |=> pf_fault_out && fault_addr_out == $past(destination_ptr_reg_in)) else $error("no page fault");
  a_slot_valid: assert property (state == S_SLOT && !rsv_info && pt_f == PT_CONTROL
    && !slot_in_use_in && slot_valid_in |=> pf_fault_out && !gp_fault_out) else $error("valid slot reused");
  a_save_feature_mask_low: assert property (state == S_CHECK && (save_feature_mask_f & SAVE_FEATURE_MASK_REQ) != SAVE_FEATURE_MASK_REQ
    |=> gp_fault_out ##1 done_out && !map_seen) else $error("feature mask not checked");
  a_size_min: assert property (state == S_CHECK && size_f < MIN_SIZE |=> gp_fault_out) else $error("small size passed");
  a_copy_len: assert property ($rose(pm_we_out) |-> wr_count == 10'(PAGE_WORDS + 2)) else $error("copy length wrong");
  a_digest_seq: assert property (digest_init_out |-> ##[1:4] (digest_update_out
    && digest_count_out == 32'h0000_0001 && digest_block_out[63:0] == OP_TAG)) else $error("digest order wrong");
  a_map_entry: assert property (pm_we_out |-> pm_valid_out && pm_rwx_out == 3'h0 && pm_flags_out == 4'h0
    && pm_addr_out == '0 ##1 done_out && !gp_fault_out && !pf_fault_out) else $error("bad map entry");
  a_fault_nomap: assert property ($rose(done_out) && (gp_fault_out || pf_fault_out)
    |-> !map_seen) else $error("map written on fault");
endmodule // container_create
`default_nettype wire

// ===== mem_model.sv
// memory model answering the word reads of the creation leaf
// assumes one clock and a request held until its ack
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input  wire logic        clock_in,
  input  wire logic        req_in,
  input  wire logic [63:0] addr_in,
  output logic      [63:0] data_out,
  output logic             ack_out
);
  logic [63:0] mem [logic [63:0]];
  initial {data_out, ack_out} = '0;
  // ===========================================
  // answer path
  // random-length stalls, at least one cycle after each ack; data inverted every cycle between acks, so a stale word returns every other cycle
  always @(posedge clock_in) begin
    ack_out <= 1'b0;
    data_out <= ~data_out;
    if (req_in && !ack_out && $urandom_range(0, 1) == 0) begin
      ack_out <= 1'b1;
      data_out <= mem.exists(addr_in) ? mem[addr_in] : 64'h0;
    end
  end
endmodule // mem_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the container creation leaf
// assumes mem_model serves descriptor, info record and source page
`timescale 1ns/10ps
`default_nettype none
module tb;
  import create_pkg::*;
  localparam logic [63:0] D = 64'h8000, X = 64'h2000;
  logic clock_in = '0, sys_rst_in = '1, reg_wr_in = '0, reg_rd_in = '0, start_in = '0;
  logic slot_in_use_in = '0, slot_valid_in = '0, rd_d = '0;
  logic [7:0] reg_addr_in = '0, pm_type_out;
  logic [31:0] reg_wdata_in = '0, leaf_select_reg_in = '0, save_need_in = '0, reg_rdata_out, slot_index_out;
  logic [63:0] descriptor_ptr_reg_in = '0, destination_ptr_reg_in = '0, mem_data_in, fault_addr_out;
  logic [63:0] mem_addr_out, slot_data_out, pm_addr_out, rq[$];
  logic busy_out, done_out, gp_fault_out, pf_fault_out, mem_req_out, mem_ack_in, slot_we_out;
  logic digest_init_out, digest_update_out, pm_we_out, pm_valid_out;
  logic [8:0] slot_word_out;
  logic [511:0] digest_block_out;
  logic [31:0] digest_count_out;
  logic [2:0] pm_rwx_out;
  logic [3:0] pm_flags_out;
  logic [66:0] q[$];
  int err_total = 0, num_checks = 0, pmw = 0;
  container_create dut_u (.*);
  mem_model mem_u (.clock_in, .req_in(mem_req_out), .addr_in(mem_addr_out), .data_out(mem_data_in), .ack_out(mem_ack_in));
  initial forever #5 clock_in = ~clock_in;
  function automatic void chk(string n, logic [511:0] x, logic [511:0] s);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endfunction
  // ===========================================
  // monitor: pops the oldest note whenever a result shows
  always @(posedge clock_in) begin
    if (slot_we_out) chk("slot", {448'h0, mem_u.mem[64'h9000 + 8 * slot_word_out]}, slot_data_out);
    if (digest_update_out) chk("digest", {352'h0, 64'h2000, 32'h1, OP_TAG}, digest_block_out);
    if (digest_init_out) chk("init", 33'h0, {pmw != 0, digest_count_out});
    if (pm_we_out) begin
      pmw++;
      chk("map", {PT_CONTROL, 64'h0, 7'h0, 1'b1, 32'h1},
          {pm_type_out, pm_addr_out, pm_rwx_out, pm_flags_out, pm_valid_out, digest_count_out});
      chk("index", X >> PAGE_SHIFT, slot_index_out);
    end
    if (done_out) begin
      chk("result", q.pop_front(), {fault_addr_out, pmw != 0, pf_fault_out, gp_fault_out});
      pmw = 0;
    end
    if (rd_d) chk("rdata", rq.pop_front(), reg_rdata_out);
    rd_d <= reg_rd_in;
  end
  task automatic rd(logic [7:0] a, logic [31:0] x);
    rq.push_back(x);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  // r holds {map write, page fault, protection fault}
  task automatic build(logic [63:0] d, logic [63:0] x, logic [2:0] r);
    q.push_back({r[1] ? x : 64'h0, r});
    @(posedge clock_in);
    start_in <= 1'b1;
    descriptor_ptr_reg_in <= d;
    destination_ptr_reg_in <= x;
    save_need_in <= $urandom_range(1, 4096);
    @(posedge clock_in);
    start_in <= 1'b0;
    repeat (4000) begin
      @(posedge clock_in);
      #1;
      if (done_out) break;
    end
  endtask
  // corrupt one memory word for one build, then restore it
  task automatic bad(logic [63:0] a, logic [63:0] v);
    logic [63:0] keep;
    keep = mem_u.mem[a];
    mem_u.mem[a] = v;
    build(D, X, 3'b001);
    mem_u.mem[a] = keep;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock_in);
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0516FF29));
    for (int i = 0; i < 512; i++) mem_u.mem[64'h9000 + 8 * i] = (i < 10) ? 64'h0 : {$urandom, $urandom};
    mem_u.mem[64'h8008] = 64'h9000;
    mem_u.mem[64'h8010] = 64'hA000;
    mem_u.mem[64'h9000] = 64'h2000;
    mem_u.mem[64'h9010] = 64'h1;
    mem_u.mem[64'h9038] = 64'h3;
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    rd(REG_ATTR_LO, 32'hFF);
    rd(REG_EXP, 32'h3F1F);
    rd(8'h20, 32'h0);
    @(posedge clock_in);
    start_in <= 1'b1;
    leaf_select_reg_in <= $urandom_range(1, 255);
    @(posedge clock_in);
    start_in <= 1'b0;
    leaf_select_reg_in <= '0;
    repeat (3) @(posedge clock_in);
    #1 chk("idle", 2'b00, {busy_out, done_out});
    build(D, X, 3'b100);
    rd(REG_COUNT, 32'h1);
    build(D + 8, X, 3'b001);
    build(D, X + 64'h800, 3'b001);
    build(D, 64'h200000, 3'b010);
    @(posedge clock_in) slot_in_use_in <= 1'b1;
    build(D, X, 3'b001);
    @(posedge clock_in) {slot_in_use_in, slot_valid_in} <= 2'b01;
    build(D, X, 3'b010);
    @(posedge clock_in) slot_valid_in <= 1'b0;
    bad(64'h8008, 64'h9008);
    bad(64'h8010, 64'hA020);
    bad(64'h8000, 64'h1);
    bad(64'h8018, 64'h1000);
    bad(64'hA000, 64'h100);
    bad(64'hA038, 64'h1);
    bad(64'h9038, 64'h1);
    bad(64'h9010, 64'h0);
    bad(64'h9008, 64'h1_0000_0000);
    bad(64'h9000, 64'h8000_0000);
    bad(64'h9000, 64'h1000);
    bad(64'h9000, 64'h3000);
    bad(64'h9008, 64'h1000);
    bad(64'h9030, 64'h100);
    bad(64'h9020, 64'h1);
    wr(REG_FEAT, 32'h1);
    build(D, X, 3'b001);
    rd(REG_COUNT, 32'h1);
    repeat (3) @(posedge clock_in);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
